//--- vls_defs.svh
// Address map, field positions, reset values and masks of the serial port
`ifndef VLS_DEFS_SVH
`define VLS_DEFS_SVH
// Register addresses, kept as the address decoder compares them
`define VLS_ADDR_SHIFT 32'hFFFF_F2E0
`define VLS_ADDR_CTRL 32'hFFFF_F2E2
`define VLS_ADDR_FMT 32'h0FFF_F2E4
`define VLS_ADDR_PRE 32'hFFFF_F2E6
`define VLS_ADDR_DIV 32'h0FFF_F2E8
// Reset values
`define VLS_CTRL_RST 8'h00
`define VLS_FMT_RST 8'h00
`define VLS_PRE_RST 8'h00
`define VLS_DIV_RST 8'h7F
`define VLS_WORD_RST 16'h0000
// Writable bits; the rest read as zero
`define VLS_CTRL_MASK 8'h85
`define VLS_FMT_MASK 8'h7F
`define VLS_PRE_MASK 8'h07
`define VLS_DIV_MASK 8'h7F
// Bit positions
`define VLS_EN_BIT 7
`define VLS_MODE_BIT 2
`define VLS_SRC_BIT 0
`define VLS_CPOL_BIT 6
`define VLS_DPHA_BIT 5
`define VLS_DIR_BIT 4
`define VLS_LEN_TOP 3
// Frame lengths
`define VLS_LEN_FULL 5'h10
`define VLS_LEN_BASE 5'h08
`endif

//--- vls_peer_model.sv
// Behavioural serial peripheral on the far side of the three-wire port
module vls_peer_model #(
    parameter int EXT_HALF = 4 // Core cycles per half period of the external clock
) (
    input wire logic clock, // Core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic sck_line, // Serial clock wire level
    input wire logic so_line, // Serial data wire from the port
    input wire logic so_driven, // Port drives its data pin
    input wire logic cpol, // Active clock level
    input wire logic dpha, // Phase: sample on leading edge when high
    input wire logic msb_first, // Bit order of the frame
    input wire logic [4:0] len, // Frame length in bits
    input wire logic [15:0] tx_word, // Word sent to the port
    input wire logic arm, // Restart the frame count
    input wire logic ext_go, // Produce one frame of external clock
    output logic ext_sck, // External clock drive, still between frames
    output logic si_line, // Data toward the port
    output logic [15:0] rx_word // Word taken from the port
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sck_prev; // Last clock level seen
    logic fill; // Changing filler once the frame is over
    int idx; // Bits exchanged so far
    int ext_cnt; // Core cycles of external clock left

    // Bit index on the wire for the i-th exchanged bit
    function automatic int bitpos(input int i);
        return msb_first ? int'(len) - 1 - i : i;
    endfunction : bitpos

    // Edge detection, capture and external clock, all on the core clock
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sck_prev <= 1'b1;
            fill <= 1'b0;
            idx <= 0;
            ext_cnt <= 0;
            ext_sck <= 1'b1;
            si_line <= 1'b0;
            rx_word <= 16'h0000;
        end else begin
            sck_prev <= sck_line;
            fill <= ~fill;
            // Data moves one cycle after the index, clear of the port's sampling point
            si_line <= (idx < int'(len)) ? tx_word[bitpos(idx)] : fill;
            if (arm) begin
                idx <= 0;
                rx_word <= 16'h0000;
                ext_sck <= ~cpol;
            end else if (sck_line != sck_prev && sck_line == (dpha ? cpol : ~cpol)
                         && idx < int'(len)) begin
                rx_word[bitpos(idx)] <= so_driven ? so_line : 1'b0;
                idx <= idx + 1;
            end
            if (ext_go) begin
                ext_cnt <= 2 * int'(len) * EXT_HALF;
            end else if (ext_cnt > 0) begin
                ext_cnt <= ext_cnt - 1;
                if (ext_cnt % EXT_HALF == 1) begin
                    ext_sck <= ~ext_sck;
                end
            end
        end
    end
endmodule : vls_peer_model

//--- vls_pkg.sv
// Types shared by the serial port logic
package vls_pkg;
    typedef enum logic {VLS_IDLE, VLS_BUSY} vls_state_e; // Transfer state
    typedef logic [15:0] vls_word_t; // One serial word
endpackage : vls_pkg

//--- vls_serial_io.sv
// Transmit FIFO and the variable length clocked serial port
`include "vls_defs.svh"

// Word FIFO with registered ready and valid flags
module vls_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clock, // Core clock
    input wire logic reset_n, // Async reset, active low
    input wire logic clear, // Drop all words
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word in
    output logic out_valid, // Word available
    input wire logic out_ready, // Word taken
    output logic [WIDTH-1:0] out_data // Oldest word
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // Storage
    logic [AW-1:0] wp_reg, wp_next; // Write pointer
    logic [AW-1:0] rp_reg, rp_next; // Read pointer
    logic [CW-1:0] cnt_reg, cnt_next; // Fill level
    logic rdy_reg, rdy_next; // Not full
    logic val_reg, val_next; // Not empty
    logic push; // Write this cycle
    logic pop; // Read this cycle

    // Pointer and level update
    always_comb begin
        push = in_valid && rdy_reg;
        pop = out_ready && val_reg;
        wp_next = push ? AW'(wp_reg + 1'b1) : wp_reg;
        rp_next = pop ? AW'(rp_reg + 1'b1) : rp_reg;
        cnt_next = cnt_reg;
        if (push && !pop) begin
            cnt_next = CW'(cnt_reg + 1'b1);
        end else if (pop && !push) begin
            cnt_next = CW'(cnt_reg - 1'b1);
        end
        if (clear) begin
            wp_next = '0;
            rp_next = '0;
            cnt_next = '0;
        end
        rdy_next = cnt_next != FULL;
        val_next = cnt_next != '0;
    end

    // State registers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            rdy_reg <= 1'b1;
            val_reg <= 1'b0;
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            rdy_reg <= rdy_next;
            val_reg <= val_next;
        end
    end

    // Storage has no reset; flags guard it
    always_ff @(posedge clock) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end

    assign in_ready = rdy_reg;
    assign out_valid = val_reg;
    assign out_data = mem[rp_reg];
endmodule : vls_fifo

// Notes on behaviour
// - Disabled: no shifting, counter clear, pins released
// - Enabled: shifter runs; unused pin stays port
// - Mode selects write start or read start
// - Source bit picks pin clock or generator
// - Direction bit picks MSB or LSB first
// - Length codes 0xxx are 16, 1xxx are 8 to 15
// - Polarity and phase bits set level and edges
// - Prescaler divides core clock by two power n
// - Divider k divides source by 2k, k nonzero
// - Reset clears control, format, prescaler
// - Reset loads divider with all ones
// - Bit writes allowed only on control, format
// - Auto stop and done pulse at final edge
// - Short words sit low; upper received bits zero
module vls_serial_io
    import vls_pkg::*;
#(
    parameter int FIFO_DEPTH = 16 // Transmit words buffered
) (
    input wire logic clock, // Core clock, 250 MHz
    input wire logic reset_n, // Async reset, active low
    input wire logic [31:0] cpu_addr, // Register address
    input wire logic cpu_wr, // Byte or word write strobe
    input wire logic cpu_bit_wr, // Single bit write strobe
    input wire logic [2:0] cpu_bit_pos, // Bit for single bit write
    input wire logic [15:0] cpu_wdata, // Write data, bit value in bit 0
    input wire logic cpu_rd, // Read strobe
    output logic [15:0] cpu_rdata, // Read data, next cycle
    output logic cpu_wr_ready, // Transmit FIFO has room
    input wire logic sck_in, // Serial clock pin level
    output logic sck_out, // Serial clock drive
    output logic sck_oe, // Serial clock driven
    output logic so_out, // Serial data out
    output logic so_oe, // Serial data out driven
    input wire logic si_in, // Serial data in
    output logic transfer_done_irq, // Word done, one cycle
    output logic xfer_busy // Transfer in progress
);
    logic [7:0] ctrl_reg, ctrl_next; // serial_control
    logic [7:0] fmt_reg, fmt_next; // frame_format_setting
    logic [7:0] pre_reg, pre_next; // baud_prescaler_select
    logic [7:0] div_reg, div_next; // baud_divider_select
    logic [15:0] rdata_reg, rdata_next; // Read data
    vls_state_e st_reg, st_next; // Transfer state
    vls_word_t tx_reg, tx_next; // Word being sent
    vls_word_t rxw_reg, rxw_next; // Word being built
    vls_word_t rx_reg, rx_next; // Last received word
    logic [4:0] cnt_reg, cnt_next; // Bits sampled
    logic [13:0] brg_reg, brg_next; // Baud countdown
    logic ph_reg, ph_next; // Clock in active half
    logic sckp_reg, sckp_next; // Previous pin clock
    logic sck_reg, sck_nx; // Clock pin drive
    logic sckoe_reg, sckoe_nx; // Clock pin enable
    logic so_reg, so_nx; // Data pin drive
    logic sooe_reg, sooe_nx; // Data pin enable
    logic irq_reg, irq_nx; // Done pulse
    logic busy_reg, busy_nx; // Busy flag
    logic en, mode, src, cpol, dpha, dir; // Decoded bits
    logic [4:0] len; // Frame length in bits
    logic [13:0] reload; // Half bit period minus one
    logic sel_shift; // Shift register addressed
    logic f_valid, f_ready, f_pop, f_push; // FIFO handshake
    vls_word_t f_data; // FIFO head
    logic tick, lead, trail, smp, drv; // Edge events

    // Bit position of serial step c in the word
    function automatic logic [3:0] bit_idx(input logic [4:0] c, input logic [4:0] l,
                                           input logic d);
        logic [4:0] t;
        t = d ? 5'(l - c - 5'h01) : c;
        return t[3:0];
    endfunction : bit_idx

    // Field decode
    always_comb begin
        en = ctrl_reg[`VLS_EN_BIT];
        mode = ctrl_reg[`VLS_MODE_BIT];
        src = ctrl_reg[`VLS_SRC_BIT];
        cpol = fmt_reg[`VLS_CPOL_BIT];
        dpha = fmt_reg[`VLS_DPHA_BIT];
        dir = fmt_reg[`VLS_DIR_BIT];
        // Code 0000 is a full word, 1xxx adds to eight
        len = fmt_reg[`VLS_LEN_TOP] ? 5'(`VLS_LEN_BASE + fmt_reg[2:0]) : `VLS_LEN_FULL;
        // Period is 2^n times k core cycles per edge, two edges per bit
        reload = 14'((14'(div_reg[6:0]) << pre_reg[2:0]) - 14'h0001);
        sel_shift = cpu_addr == `VLS_ADDR_SHIFT;
    end

    // Words written in transmit mode queue up; a full FIFO drops the write
    assign f_push = cpu_wr && sel_shift && en && !mode;
    assign f_pop = (st_reg == VLS_IDLE) && en && !mode && f_valid;

    vls_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_txq (
        .clock(clock),
        .reset_n(reset_n),
        .clear(!en),
        .in_valid(f_push),
        .in_ready(f_ready),
        .in_data(cpu_wdata),
        .out_valid(f_valid),
        .out_ready(f_pop),
        .out_data(f_data)
    );

    // Register writes and read data
    always_comb begin
        ctrl_next = ctrl_reg;
        fmt_next = fmt_reg;
        pre_next = pre_reg;
        div_next = div_reg;
        if (cpu_wr) begin
            if (cpu_addr == `VLS_ADDR_CTRL) begin
                ctrl_next = cpu_wdata[7:0] & `VLS_CTRL_MASK;
            end else if (cpu_addr == `VLS_ADDR_FMT) begin
                fmt_next = cpu_wdata[7:0] & `VLS_FMT_MASK;
            end else if (cpu_addr == `VLS_ADDR_PRE) begin
                pre_next = cpu_wdata[7:0] & `VLS_PRE_MASK;
            end else if (cpu_addr == `VLS_ADDR_DIV) begin
                div_next = cpu_wdata[7:0] & `VLS_DIV_MASK;
            end
        end else if (cpu_bit_wr) begin
            // Single bit writes reach only control and format
            if (cpu_addr == `VLS_ADDR_CTRL) begin
                ctrl_next[cpu_bit_pos] = cpu_wdata[0];
                ctrl_next = ctrl_next & `VLS_CTRL_MASK;
            end else if (cpu_addr == `VLS_ADDR_FMT) begin
                fmt_next[cpu_bit_pos] = cpu_wdata[0];
                fmt_next = fmt_next & `VLS_FMT_MASK;
            end
        end
        rdata_next = rdata_reg;
        if (cpu_rd) begin
            if (sel_shift) begin
                rdata_next = rx_reg;
            end else if (cpu_addr == `VLS_ADDR_CTRL) begin
                rdata_next = {8'h00, ctrl_reg};
            end else if (cpu_addr == `VLS_ADDR_FMT) begin
                rdata_next = {8'h00, fmt_reg};
            end else if (cpu_addr == `VLS_ADDR_PRE) begin
                rdata_next = {8'h00, pre_reg};
            end else if (cpu_addr == `VLS_ADDR_DIV) begin
                rdata_next = {8'h00, div_reg};
            end else begin
                rdata_next = `VLS_WORD_RST; // Unmapped reads give zero
            end
        end
    end

    // Register state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_reg <= `VLS_CTRL_RST;
            fmt_reg <= `VLS_FMT_RST;
            pre_reg <= `VLS_PRE_RST;
            div_reg <= `VLS_DIV_RST;
            rdata_reg <= `VLS_WORD_RST;
        end else begin
            ctrl_reg <= ctrl_next;
            fmt_reg <= fmt_next;
            pre_reg <= pre_next;
            div_reg <= div_next;
            rdata_reg <= rdata_next;
        end
    end

    // Shift engine: edges, sampling, driving and stop
    always_comb begin
        st_next = st_reg;
        tx_next = tx_reg;
        rxw_next = rxw_reg;
        rx_next = rx_reg;
        cnt_next = cnt_reg;
        brg_next = brg_reg;
        ph_next = ph_reg;
        so_nx = so_reg;
        irq_nx = 1'b0;
        sckp_next = sck_in;
        tick = 1'b0;
        // Generator runs only inside a frame, so each frame starts on a full period
        if (st_reg == VLS_BUSY && src) begin
            tick = brg_reg == 14'h0000;
            brg_next = tick ? reload : 14'(brg_reg - 14'h0001);
        end else begin
            brg_next = reload;
        end
        // Leading edge leaves the idle level, trailing edge returns to it
        if (src) begin
            lead = tick && !ph_reg;
            trail = tick && ph_reg;
        end else begin
            lead = st_reg == VLS_BUSY && sck_in != sckp_reg && sck_in == cpol;
            trail = st_reg == VLS_BUSY && sck_in != sckp_reg && sck_in != cpol;
        end
        // Phase bit 0 drives on leading and samples on trailing; 1 swaps
        smp = dpha ? lead : trail;
        drv = dpha ? trail : lead;
        if (lead) begin
            ph_next = 1'b1;
        end
        if (trail) begin
            ph_next = 1'b0;
        end
        case (st_reg)
            VLS_IDLE: begin
                if (f_pop) begin
                    // Write start: first bit is on the pin before the first edge
                    st_next = VLS_BUSY;
                    tx_next = f_data;
                    rxw_next = `VLS_WORD_RST;
                    so_nx = f_data[bit_idx(5'h00, len, dir)];
                end else if (en && mode && cpu_rd && sel_shift) begin
                    st_next = VLS_BUSY; // Read start, nothing sent
                    tx_next = `VLS_WORD_RST;
                    rxw_next = `VLS_WORD_RST;
                end
            end
            VLS_BUSY: begin
                if (drv && cnt_reg < len) begin
                    so_nx = tx_reg[bit_idx(cnt_reg, len, dir)];
                end
                if (smp) begin
                    // Unused upper bits were cleared at start
                    rxw_next[bit_idx(cnt_reg, len, dir)] = si_in;
                    cnt_next = 5'(cnt_reg + 5'h01);
                end
                // Stop after the last bit on the final clock edge
                if (trail && cnt_next == len) begin
                    st_next = VLS_IDLE;
                    cnt_next = 5'h00;
                    rx_next = rxw_next;
                    irq_nx = 1'b1;
                end
            end
            default: st_next = VLS_IDLE;
        endcase
        // Disable aborts the frame and holds the counter clear
        if (!en) begin
            st_next = VLS_IDLE;
            cnt_next = 5'h00;
            ph_next = 1'b0;
            irq_nx = 1'b0;
        end
        sck_nx = ph_next ? cpol : !cpol;
        sckoe_nx = en && src;
        sooe_nx = en && !mode;
        busy_nx = st_next == VLS_BUSY;
    end

    // Shift engine state
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= VLS_IDLE;
            tx_reg <= `VLS_WORD_RST;
            rxw_reg <= `VLS_WORD_RST;
            rx_reg <= `VLS_WORD_RST;
            cnt_reg <= 5'h00;
            brg_reg <= 14'h0000;
            ph_reg <= 1'b0;
            sckp_reg <= 1'b1;
            sck_reg <= 1'b1;
            sckoe_reg <= 1'b0;
            so_reg <= 1'b0;
            sooe_reg <= 1'b0;
            irq_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            tx_reg <= tx_next;
            rxw_reg <= rxw_next;
            rx_reg <= rx_next;
            cnt_reg <= cnt_next;
            brg_reg <= brg_next;
            ph_reg <= ph_next;
            sckp_reg <= sckp_next;
            sck_reg <= sck_nx;
            sckoe_reg <= sckoe_nx;
            so_reg <= so_nx;
            sooe_reg <= sooe_nx;
            irq_reg <= irq_nx;
            busy_reg <= busy_nx;
        end
    end

    assign cpu_rdata = rdata_reg;
    assign cpu_wr_ready = f_ready;
    assign sck_out = sck_reg;
    assign sck_oe = sckoe_reg;
    assign so_out = so_reg;
    assign so_oe = sooe_reg;
    assign transfer_done_irq = irq_reg;
    assign xfer_busy = busy_reg;

    a_off_idle: assert property (@(posedge clock) disable iff (!reset_n)
        !en |=> !xfer_busy && cnt_reg == 5'h00 && !sck_oe && !so_oe)
        else $error("disabled port not idle");
    a_rx_only: assert property (@(posedge clock) disable iff (!reset_n)
        en && mode |=> !so_oe)
        else $error("data out driven in receive mode");
    a_read_start: assert property (@(posedge clock) disable iff (!reset_n)
        st_reg == VLS_IDLE && en && mode && cpu_rd && sel_shift |=> xfer_busy)
        else $error("read did not start transfer");
    a_pin_clock: assert property (@(posedge clock) disable iff (!reset_n)
        en && !src |=> !sck_oe)
        else $error("clock driven with pin source");
    a_bit_count: assert property (@(posedge clock) disable iff (!reset_n)
        irq_nx |-> cnt_reg == len || (cnt_reg == 5'(len - 5'h01) && smp))
        else $error("frame ended at wrong bit count");
    a_idle_level: assert property (@(posedge clock) disable iff (!reset_n)
        !ph_reg |=> sck_out == !$past(cpol) || ph_reg)
        else $error("clock not at idle level");
    a_brg_reload: assert property (@(posedge clock) disable iff (!reset_n)
        tick |=> brg_reg == $past(reload))
        else $error("baud counter reload wrong");
    a_pre_bits: assert property (@(posedge clock) disable iff (!reset_n)
        cpu_bit_wr && cpu_addr == `VLS_ADDR_PRE && !cpu_wr |=> $stable(pre_reg))
        else $error("bit write changed prescaler");
    a_done_stop: assert property (@(posedge clock) disable iff (!reset_n)
        transfer_done_irq |-> !xfer_busy ##1 !transfer_done_irq)
        else $error("done pulse without stop");
endmodule : vls_serial_io

//--- vls_serial_io_test.sv
// Self-checking bench of the variable length serial port
`include "vls_defs.svh"
module vls_serial_io_test
    import vls_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 0, reset_n = 0, cpu_wr = 0, cpu_bit_wr = 0, cpu_rd = 0; // Bus controls
    logic [31:0] cpu_addr = 0; // Register address
    logic [2:0] cpu_bit_pos = 0; // Bit write position
    vls_word_t cpu_wdata = 0, cpu_rdata, p_tx = 0, p_rx, rdv; // Data words
    logic cpu_wr_ready, sck_out, sck_oe, so_out, so_oe, si_in, transfer_done_irq, xfer_busy;
    logic p_cpol = 0, p_dpha = 0, p_dir = 0, p_arm = 0, p_ext_go = 0, ext_sck; // Peer setup
    logic [4:0] p_len = 5'h08; // Peer frame length
    wire sck_line = sck_oe ? sck_out : ext_sck; // Wire level seen by both ends
    int miscompares = 0, num_checks = 0, irq_cnt = 0;

    vls_serial_io u_vls_serial_io (.clock(clock), .reset_n(reset_n), .cpu_addr(cpu_addr),
        .cpu_wr(cpu_wr), .cpu_bit_wr(cpu_bit_wr), .cpu_bit_pos(cpu_bit_pos),
        .cpu_wdata(cpu_wdata), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
        .cpu_wr_ready(cpu_wr_ready), .sck_in(sck_line), .sck_out(sck_out), .sck_oe(sck_oe),
        .so_out(so_out), .so_oe(so_oe), .si_in(si_in), .transfer_done_irq(transfer_done_irq),
        .xfer_busy(xfer_busy));
    vls_peer_model u_vls_peer_model (.clock(clock), .reset_n(reset_n), .sck_line(sck_line),
        .so_line(so_out), .so_driven(so_oe), .cpol(p_cpol), .dpha(p_dpha), .msb_first(p_dir),
        .len(p_len), .tx_word(p_tx), .arm(p_arm), .ext_go(p_ext_go), .ext_sck(ext_sck),
        .si_line(si_in), .rx_word(p_rx));

    // 250 MHz core clock
    initial begin
        forever #2 clock = ~clock;
    end
    // Done pulses are counted so refused or aborted words show as a wrong count
    always @(posedge clock) begin
        if (transfer_done_irq === 1'b1) irq_cnt <= irq_cnt + 1;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // Bus cycles: one strobe pulse, driven at the falling edge
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(negedge clock); cpu_addr = a; cpu_wdata = d; cpu_wr = 1;
        @(negedge clock); cpu_wr = 0;
    endtask : wr
    task automatic bwr(input logic [31:0] a, input logic [2:0] p, input logic v);
        @(negedge clock); cpu_addr = a; cpu_bit_pos = p; cpu_wdata = {15'h0, v}; cpu_bit_wr = 1;
        @(negedge clock); cpu_bit_wr = 0;
    endtask : bwr
    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        @(negedge clock); cpu_addr = a; cpu_rd = 1;
        @(negedge clock); cpu_rd = 0; d = cpu_rdata;
    endtask : rd
    task automatic arm(input logic [7:0] fmt, input logic [15:0] tx);
        wr(`VLS_ADDR_FMT, {8'h00, fmt});
        p_cpol = fmt[6]; p_dpha = fmt[5]; p_dir = fmt[4]; p_tx = tx;
        p_len = (fmt[3:0] == 4'h0) ? 5'h10 : {2'b01, fmt[2:0]};
        @(negedge clock); p_arm = 1; @(negedge clock); p_arm = 0;
    endtask : arm
    task automatic wait_irq(input int n, input int max);
        for (int i = 0; i < max && irq_cnt < n; i++) @(negedge clock);
        chk("done count", 16'(n), 16'(irq_cnt));
    endtask : wait_irq
    function automatic logic [15:0] lmask();
        return (p_len == 5'h10) ? 16'hFFFF : 16'((17'h1 << p_len) - 1);
    endfunction : lmask

    task automatic t_reset();
        rd(`VLS_ADDR_CTRL, rdv); chk("control", 16'h0000, rdv);
        rd(`VLS_ADDR_FMT, rdv); chk("format", 16'h0000, rdv);
        rd(`VLS_ADDR_PRE, rdv); chk("prescaler", 16'h0000, rdv);
        rd(`VLS_ADDR_DIV, rdv); chk("divider", 16'h007F, rdv);
        rd(32'hFFFF_F2EA, rdv); chk("unmapped", 16'h0000, rdv);
        chk("pin drive", 16'h0000, {14'h0, sck_oe, so_oe});
    endtask : t_reset
    task automatic t_regs();
        logic [31:0] ad [4] = '{`VLS_ADDR_CTRL, `VLS_ADDR_FMT, `VLS_ADDR_PRE, `VLS_ADDR_DIV};
        logic [7:0] mk [4] = '{8'h85, 8'h7F, 8'h07, 8'h7F};
        for (int i = 0; i < 4; i++) begin
            wr(ad[i], 16'h00FF); rd(ad[i], rdv); chk("byte write", {8'h0, mk[i]}, rdv);
            wr(ad[i], 16'h0000);
        end
        bwr(`VLS_ADDR_CTRL, 3'd7, 1); rd(`VLS_ADDR_CTRL, rdv); chk("bit ctrl", 16'h0080, rdv);
        bwr(`VLS_ADDR_FMT, 3'd4, 1); rd(`VLS_ADDR_FMT, rdv); chk("bit fmt", 16'h0010, rdv);
        bwr(`VLS_ADDR_PRE, 3'd1, 1); rd(`VLS_ADDR_PRE, rdv); chk("bit pre", 16'h0000, rdv);
        wr(`VLS_ADDR_CTRL, 16'h0000);
    endtask : t_regs
    // Pin ownership for every mode and source combination while enabled, and once disabled
    task automatic t_pins();
        logic [7:0] cv [5] = '{8'h80, 8'h81, 8'h84, 8'h85, 8'h00};
        for (int i = 0; i < 5; i++) begin
            wr(`VLS_ADDR_CTRL, {8'h0, cv[i]}); @(negedge clock);
            chk("oe pair", {14'h0, cv[i][7] & cv[i][0], cv[i][7] & ~cv[i][2]},
                {14'h0, sck_oe, so_oe});
        end
    endtask : t_pins
    // Length codes 0 and 8 to 15, every order and clock shape, both directions of data
    task automatic t_frames();
        logic [3:0] code;
        logic [15:0] tx;
        wr(`VLS_ADDR_DIV, 16'h0002); wr(`VLS_ADDR_CTRL, 16'h0081);
        for (int c = 0; c < 9; c++) begin
            code = (c == 8) ? 4'h0 : 4'(8 + c);
            tx = 16'hA5C3 ^ 16'(c * 16'h1111);
            arm({1'b0, 1'(c >> 1), 1'(c), 1'(c >> 2), code}, ~tx);
            wr(`VLS_ADDR_SHIFT, tx); wait_irq(irq_cnt + 1, 600);
            chk("peer word", tx & lmask(), p_rx);
            rd(`VLS_ADDR_SHIFT, rdv); chk("rx word", ~tx & lmask(), rdv);
            chk("idle", {14'h0, ~p_cpol, 1'b0}, {14'h0, sck_out, xfer_busy});
        end
    endtask : t_frames
    // Half period of the generator for two prescaler and divider pairs
    task automatic t_rate();
        logic [15:0] set [2] = '{16'h0203, 16'h0701};
        logic s;
        int n;
        for (int i = 0; i < 2; i++) begin
            wr(`VLS_ADDR_PRE, {8'h0, set[i][15:8]}); wr(`VLS_ADDR_DIV, {8'h0, set[i][7:0]});
            arm(8'h08, 16'h0000); wr(`VLS_ADDR_SHIFT, 16'h0055);
            s = sck_out; n = 0;
            while (sck_out === s && n < 400) begin @(negedge clock); n++; end
            s = sck_out; n = 0;
            while (sck_out === s && n < 400) begin @(negedge clock); n++; end
            chk("half period", 16'((1 << set[i][15:8]) * set[i][7:0]), 16'(n));
            wait_irq(irq_cnt + 1, 2200);
        end
        wr(`VLS_ADDR_PRE, 16'h0000); wr(`VLS_ADDR_DIV, 16'h0002);
    endtask : t_rate
    // Receive-only: a read starts the frame and the data pin stays a port
    task automatic t_rx_only();
        wr(`VLS_ADDR_CTRL, 16'h0085); arm(8'h1C, 16'h3A5C);
        rd(`VLS_ADDR_SHIFT, rdv); chk("so port", 16'h0000, {15'h0, so_oe});
        wait_irq(irq_cnt + 1, 400);
        rd(`VLS_ADDR_SHIFT, rdv); chk("rx only", 16'h0A5C, rdv);
        wait_irq(irq_cnt + 1, 400); wr(`VLS_ADDR_CTRL, 16'h0000);
    endtask : t_rx_only
    // External clock from the peer
    task automatic t_ext();
        wr(`VLS_ADDR_CTRL, 16'h0080); arm(8'h08, 16'h00C6);
        wr(`VLS_ADDR_SHIFT, 16'h0039); repeat (3) @(negedge clock);
        p_ext_go = 1; @(negedge clock); p_ext_go = 0;
        wait_irq(irq_cnt + 1, 200); chk("ext peer", 16'h0039, p_rx);
        rd(`VLS_ADDR_SHIFT, rdv); chk("ext rx", 16'h00C6, rdv);
    endtask : t_ext
    // Disable in mid-frame: stops, no done pulse, clock pin released
    task automatic t_abort();
        int base;
        wr(`VLS_ADDR_DIV, 16'h0008); wr(`VLS_ADDR_CTRL, 16'h0081); arm(8'h08, 16'h0000);
        base = irq_cnt; wr(`VLS_ADDR_SHIFT, 16'h00AA); repeat (40) @(negedge clock);
        wr(`VLS_ADDR_CTRL, 16'h0000); repeat (3) @(negedge clock);
        chk("abort", 16'h0000, {14'h0, xfer_busy, sck_oe});
        repeat (300) @(negedge clock); chk("no done", 16'(base), 16'(irq_cnt));
    endtask : t_abort
    // Fill the transmit FIFO until it refuses, then let it drain
    task automatic t_fifo();
        int base;
        wr(`VLS_ADDR_CTRL, 16'h0081); arm(8'h08, 16'h0000); base = irq_cnt;
        for (int i = 0; i < 17; i++) wr(`VLS_ADDR_SHIFT, 16'(i));
        chk("fifo full", 16'h0000, {15'h0, cpu_wr_ready});
        wr(`VLS_ADDR_SHIFT, 16'h00EE);
        wait_irq(base + 17, 4000); repeat (300) @(negedge clock);
        chk("drained", 16'(base + 17), 16'(irq_cnt)); chk("room", 16'h0001, {15'h0, cpu_wr_ready});
    endtask : t_fifo

    // Watchdog well beyond the expected run length
    initial begin
        #(40000 * 4);
        miscompares++;
        summarize();
    end
    // Main sequence: reset for six cycles, then the scenarios in turn
    initial begin
        repeat (6) @(negedge clock);
        reset_n = 1;
        t_reset(); t_regs(); t_pins(); t_frames(); t_rate();
        t_rx_only(); t_ext(); t_abort(); t_fifo();
        summarize();
    end
endmodule : vls_serial_io_test
